// ### rtl/pltb_link_train.v
`timescale 1ns/1ns
`include "pltb_regs.vh"
module pltb_link_train #(
	parameter lane_count_param       = 1,
	parameter symbols_per_lane_param = 2,
	parameter speed_generation_param = 2,
	parameter DOWNSTREAM             = 1
)(
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset,
	// link control register image and reference clock gate
	input  wire [15:0] link_control,
	input  wire        pcie_refclk_enable,
	// transmit side requests
	input  wire        tlp_pending,
	input  wire        cfg_accept_enter,
	// receive symbols from the phy
	input  wire        rx_ts1,
	input  wire        rx_skp,
	input  wire        rx_eieos,
	input  wire        rx_eios,
	input  wire        rx_ack,
	input  wire        rx_tlp,
	input  wire        rx_decode_err,
	input  wire        rx_link_lane_match,
	// transmit symbols to the phy
	output wire        tx_fts,
	output wire        tx_skp,
	output reg         tx_ts1_r,
	output reg         tx_ts1_lane_valid_r,
	output reg         tx_err_msg_r,
	output reg         tx_ack_r,
	output reg         tx_replay_r,
	output reg         retrain_req_r,
	// state
	output reg  [7:0]  ltssm_state_r
);
	// ==========================================================
	// configuration decode
	wire l0s_en    = link_control[`PLTB_LC_ASPM_L0S];
	wire ext_synch = link_control[`PLTB_LC_EXT_SYNCH];
	wire wide_lane = (symbols_per_lane_param >= `PLTB_WIDE_SYMS)
	                 && (speed_generation_param == `PLTB_GEN12_MODE);
	wire single_ln = (lane_count_param == `PLTB_ONE_LANE);
	// single-lane builds never look at the match flag
	wire match_ok  = single_ln | rx_link_lane_match;

	// ==========================================================
	// ltssm states, one hot
	localparam [7:0] ST_L0         = `PLTB_ST_L0;
	localparam [7:0] ST_L0S        = `PLTB_ST_L0S;
	localparam [7:0] ST_L0S_EXIT   = `PLTB_ST_L0S_EXIT;
	localparam [7:0] ST_CFG_ACCEPT = `PLTB_ST_CFG_ACCEPT;
	localparam [7:0] ST_RCV_LOCK   = `PLTB_ST_RCV_LOCK;
	localparam [7:0] ST_RCV_CFG    = `PLTB_ST_RCV_CFG;
	localparam [7:0] ST_RCV_IDLE   = `PLTB_ST_RCV_IDLE;
	localparam [7:0] ST_DETECT     = `PLTB_ST_DETECT;

	reg  [7:0]  state_nxt;
	reg  [15:0] idle_cnt_r;
	reg  [1:0]  ts1_cnt_r;
	reg  [15:0] replay_tmr_r;
	reg  [1:0]  replay_cnt_r;
	reg         msg_pending_r;
	reg         ack_hold_r;
	reg         tlp_hold_r;
	reg         fts_start_r;
	wire        fts_done;

	// ==========================================================
	// fts generator
	pltb_fts_gen #(
		.CNT_W (`PLTB_FTS_CNT_W)
	) u_fts (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.start      (fts_start_r),
		.ext_synch  (ext_synch),
		.wide_lane  (wide_lane),
		.fts_send_r (tx_fts),
		.skp_send_r (tx_skp),
		.done_r     (fts_done)
	);

	// ==========================================================
	// next state
	always @*
	begin
		state_nxt = ltssm_state_r;
		case (ltssm_state_r)
		ST_DETECT:
			if (pcie_refclk_enable)
				state_nxt = ST_L0;
		ST_L0:
			if (retrain_req_r)
				state_nxt = ST_RCV_LOCK;
			else if (rx_ts1 && ts1_cnt_r == `PLTB_TS1_TO_RCV - 2'h1)
				state_nxt = ST_RCV_LOCK;
			else if (cfg_accept_enter)
				state_nxt = ST_CFG_ACCEPT;
			else if (l0s_en && idle_cnt_r == `PLTB_L0S_ENTRY_CYC)
				state_nxt = ST_L0S;
		ST_L0S:
			if (tlp_pending)
				state_nxt = ST_L0S_EXIT;
		ST_L0S_EXIT:
			if (fts_done)
				state_nxt = ST_L0;
		ST_CFG_ACCEPT:
			state_nxt = ST_L0;
		ST_RCV_LOCK:
			if (rx_ts1 && match_ok)
				state_nxt = ST_RCV_CFG;
		ST_RCV_CFG:
			if (rx_ts1 && match_ok)
				state_nxt = ST_RCV_IDLE;
		ST_RCV_IDLE:
			state_nxt = ST_L0;
		default:
			state_nxt = ST_DETECT;
		endcase
		if (!pcie_refclk_enable)
			state_nxt = ST_DETECT;
	end

	// ==========================================================
	// state, counters and transmit strobes
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			ltssm_state_r       <= ST_DETECT;
			idle_cnt_r          <= 16'h0000;
			ts1_cnt_r           <= 2'h0;
			fts_start_r         <= 1'b0;
			tx_ts1_r            <= 1'b0;
			tx_ts1_lane_valid_r <= 1'b0;
		end
		else
		begin
			ltssm_state_r <= state_nxt;
			fts_start_r   <= (state_nxt == ST_L0S_EXIT)
			                 && (ltssm_state_r == ST_L0S);
			// idle counter restarts on a pending or received tlp, or outside l0
			if (ltssm_state_r != ST_L0 || tlp_pending || rx_tlp)
				idle_cnt_r <= 16'h0000;
			else if (idle_cnt_r != `PLTB_L0S_ENTRY_CYC)
				idle_cnt_r <= idle_cnt_r + 16'h0001;
			// a skp or eieos between ts1 sets loses the first one
			if (ltssm_state_r != ST_L0 || rx_skp || rx_eieos)
				ts1_cnt_r <= 2'h0;
			else if (rx_ts1)
				ts1_cnt_r <= ts1_cnt_r + 2'h1;
			// downstream builds only: non-pad lane number from the first accept cycle, no wait
			tx_ts1_r <= (state_nxt == ST_CFG_ACCEPT)
			            || (state_nxt == ST_RCV_LOCK)
			            || (state_nxt == ST_RCV_CFG);
			tx_ts1_lane_valid_r <= (DOWNSTREAM != 0)
			                       && (state_nxt == ST_CFG_ACCEPT);
		end
	end

	// ==========================================================
	// data link: ack, error message and replay
	// an ack or tlp followed directly by eios is dropped by the receive path
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			ack_hold_r    <= 1'b0;
			tlp_hold_r    <= 1'b0;
			tx_ack_r      <= 1'b0;
			tx_replay_r   <= 1'b0;
			tx_err_msg_r  <= 1'b0;
			msg_pending_r <= 1'b0;
			replay_tmr_r  <= 16'h0000;
			replay_cnt_r  <= 2'h0;
			retrain_req_r <= 1'b0;
		end
		else
		begin
			ack_hold_r   <= rx_ack;
			tlp_hold_r   <= rx_tlp;
			tx_ack_r     <= tlp_hold_r && !rx_eios;
			tx_replay_r  <= 1'b0;
			tx_err_msg_r <= 1'b0;
			// reaching recovery clears the request; a rollover in that cycle still wins
			if (ltssm_state_r == ST_RCV_LOCK)
				retrain_req_r <= 1'b0;
			// a fresh decode error goes first so a stray ack cannot swallow it
			if (rx_decode_err && !msg_pending_r)
			begin
				tx_err_msg_r  <= 1'b1;
				msg_pending_r <= 1'b1;
				replay_tmr_r  <= 16'h0000;
				replay_cnt_r  <= 2'h0;
			end
			// ack accepted only if not chased by eios
			else if (ack_hold_r && !rx_eios)
			begin
				msg_pending_r <= 1'b0;
				replay_tmr_r  <= 16'h0000;
				replay_cnt_r  <= 2'h0;
			end
			else if (msg_pending_r)
			begin
				if (replay_tmr_r == `PLTB_REPLAY_CYC)
				begin
					replay_tmr_r <= 16'h0000;
					if (replay_cnt_r == `PLTB_REPLAY_MAX)
					begin
						retrain_req_r <= 1'b1;
						msg_pending_r <= 1'b0;
						replay_cnt_r  <= 2'h0;
					end
					else
					begin
						tx_replay_r  <= 1'b1;
						tx_err_msg_r <= 1'b1;
						replay_cnt_r <= replay_cnt_r + 2'h1;
					end
				end
				else
					replay_tmr_r <= replay_tmr_r + 16'h0001;
			end
		end
	end
endmodule // pltb_link_train

// ### rtl/pltb_regs.vh
`ifndef PLTB_REGS_VH
`define PLTB_REGS_VH
// ==========================================================
// link control bit positions
`define PLTB_LC_ASPM_L0S     0
`define PLTB_LC_EXT_SYNCH    7
// ==========================================================
// fast training sequence counts
`define PLTB_FTS_NORMAL      13'h1000
`define PLTB_FTS_EXTENDED    13'h1001
`define PLTB_FTS_CNT_W       13
// skp ordered sets inserted among extended fts
`define PLTB_SKP_MIN         4'hC
`define PLTB_SKP_SPACING     13'h0155
// ==========================================================
// l0s entry latency and replay timing in core cycles; replay limit and ts1 count to recovery
`define PLTB_L0S_ENTRY_CYC   16'h0020
`define PLTB_REPLAY_CYC      16'h0400
`define PLTB_REPLAY_MAX      2'h3
`define PLTB_TS1_TO_RCV      2'h2
// ==========================================================
// build options that select the as-built behaviour
`define PLTB_WIDE_SYMS       2
`define PLTB_GEN12_MODE      2
`define PLTB_ONE_LANE        1
// ==========================================================
// ltssm state codes (one hot)
`define PLTB_ST_L0           8'h01
`define PLTB_ST_L0S          8'h02
`define PLTB_ST_L0S_EXIT     8'h04
`define PLTB_ST_CFG_ACCEPT   8'h08
`define PLTB_ST_RCV_LOCK     8'h10
`define PLTB_ST_RCV_CFG      8'h20
`define PLTB_ST_RCV_IDLE     8'h40
`define PLTB_ST_DETECT       8'h80
`endif

// ### rtl/pltb_fts_gen.v
`timescale 1ns/1ns
`include "pltb_regs.vh"
// ==========================================================
// fast training sequence generator for l0s exit
module pltb_fts_gen #(
	parameter CNT_W = `PLTB_FTS_CNT_W
)(
	// clock and reset
	input  wire             clk_sys,
	input  wire             reset,
	// control
	input  wire             start,
	input  wire             ext_synch,
	input  wire             wide_lane,
	// output stream
	output reg              fts_send_r,
	output reg              skp_send_r,
	output reg              done_r
);
	reg  [CNT_W-1:0] cnt_r;
	reg  [CNT_W-1:0] gap_r;
	reg  [3:0]       skp_cnt_r;
	reg              busy_r;
	reg  [CNT_W-1:0] final_r;
	wire [CNT_W-1:0] final_nxt;

	// extended synch on a wide lane overshoots by one sequence
	assign final_nxt = (ext_synch && wide_lane) ? `PLTB_FTS_EXTENDED
	                 : `PLTB_FTS_NORMAL;

	// skp takes a slot of its own without advancing cnt_r, so the fts count stays exact
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cnt_r      <= {CNT_W{1'b0}};
			gap_r      <= {CNT_W{1'b0}};
			skp_cnt_r  <= 4'h0;
			busy_r     <= 1'b0;
			final_r    <= {CNT_W{1'b0}};
			fts_send_r <= 1'b0;
			skp_send_r <= 1'b0;
			done_r     <= 1'b0;
		end
		else
		begin
			done_r     <= 1'b0;
			fts_send_r <= 1'b0;
			skp_send_r <= 1'b0;
			if (start && !busy_r)
			begin
				busy_r    <= 1'b1;
				cnt_r     <= {CNT_W{1'b0}};
				gap_r     <= {CNT_W{1'b0}};
				skp_cnt_r <= 4'h0;
				final_r   <= final_nxt;
			end
			else if (busy_r)
			begin
				if (cnt_r == final_r)
				begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
				else if (ext_synch && gap_r == `PLTB_SKP_SPACING
				         && skp_cnt_r < `PLTB_SKP_MIN)
				begin
					skp_send_r <= 1'b1;
					skp_cnt_r  <= skp_cnt_r + 4'h1;
					gap_r      <= {CNT_W{1'b0}};
				end
				else
				begin
					fts_send_r <= 1'b1;
					cnt_r      <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
					gap_r      <= gap_r + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // pltb_fts_gen

// ### verif/pltb_checker.sv
`timescale 1ns/1ns
`include "pltb_regs.vh"
// ==========================================================
// port level checks on the link training block
module pltb_checker (
	// clock and reset
	input wire        clk_sys,
	input wire        reset,
	// causes
	input wire [15:0] link_control,
	input wire        pcie_refclk_enable,
	input wire        rx_ts1,
	input wire        rx_eios,
	input wire        rx_tlp,
	input wire        rx_decode_err,
	// effects
	input wire        tx_fts,
	input wire        tx_skp,
	input wire        tx_ts1_lane_valid_r,
	input wire        tx_err_msg_r,
	input wire        tx_ack_r,
	input wire        tx_replay_r,
	input wire        retrain_req_r,
	input wire [7:0]  ltssm_state_r
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// short alias keeps each property on one line
	wire [7:0] st = ltssm_state_r;
	// acks follow a tlp by two cycles unless eios swallowed it
	tlp_ack_a: assert property (rx_tlp ##1 !rx_eios |=> tx_ack_r)
		else $error("tlp not acked");
	tlp_lost_a: assert property (rx_tlp ##1 rx_eios |=> !tx_ack_r)
		else $error("lost tlp acked");
	// first message comes straight after the decode error
	err_first_a: assert property ($rose(tx_err_msg_r) && !tx_replay_r |-> $past(rx_decode_err))
		else $error("message without decode error");
	replay_msg_a: assert property (tx_replay_r |-> tx_err_msg_r)
		else $error("replay without message");
	cfg_lane_a: assert property (st == `PLTB_ST_CFG_ACCEPT |-> ##[0:1] tx_ts1_lane_valid_r)
		else $error("pad lane in accept");
	// recovery walks on ts1 alone in single-lane builds, where lane match is not looked at
	lock_adv_a: assert property (st == `PLTB_ST_RCV_LOCK && rx_ts1 |=> st == `PLTB_ST_RCV_CFG)
		else $error("lock did not advance");
	cfg_adv_a: assert property (st == `PLTB_ST_RCV_CFG && rx_ts1 |=> st == `PLTB_ST_RCV_IDLE)
		else $error("rcvcfg did not advance");
	wake_tx_a: assert property (tx_fts || tx_skp |-> st == `PLTB_ST_L0S_EXIT && !(tx_fts && tx_skp))
		else $error("wake stream out of place");
	retrain_a: assert property ($rose(retrain_req_r) |=> st == `PLTB_ST_RCV_LOCK)
		else $error("retrain without recovery");
	refclk_a: assert property (!pcie_refclk_enable |=> st == `PLTB_ST_DETECT)
		else $error("running without refclk");
	l0s_en_a: assert property ($rose(st == `PLTB_ST_L0S) |-> $past(link_control[`PLTB_LC_ASPM_L0S]))
		else $error("l0s while disabled");
	ts1_lock_a: assert property ($rose(st == `PLTB_ST_RCV_LOCK) |-> $past(rx_ts1) || $past(retrain_req_r))
		else $error("recovery without cause");
	// main scenarios reached
	cover property (tx_skp);
	cover property ($rose(retrain_req_r));
	cover property (st == `PLTB_ST_RCV_IDLE);
endmodule // pltb_checker

bind pltb_link_train pltb_checker i_checker (.clk_sys, .reset, .link_control,
	.pcie_refclk_enable, .rx_ts1, .rx_eios, .rx_tlp, .rx_decode_err, .tx_fts, .tx_skp,
	.tx_ts1_lane_valid_r, .tx_err_msg_r, .tx_ack_r, .tx_replay_r, .retrain_req_r,
	.ltssm_state_r);

// ### verif/pltb_partner.sv
`timescale 1ns/1ns
// ==========================================================
// far link partner: sends receive symbols, watches the wake stream
module pltb_partner (
	// clock
	input wire  clk_sys,
	// stream from the device
	input wire  tx_fts,
	input wire  tx_skp,
	input wire  tx_replay_r,
	input wire  tx_err_msg_r,
	// symbols to the device
	output wire rx_ts1,
	output wire rx_skp,
	output wire rx_eieos,
	output wire rx_eios,
	output wire rx_ack,
	output wire rx_tlp,
	output wire rx_decode_err
);
	// receive timeout in fts periods, inside the allowed window
	localparam NFTS_TIMEOUT = 3072;
	reg [6:0] sym_r = 7'h00;
	integer   fts_cnt = 0;
	integer   skp_cnt = 0;
	integer   dup_cnt = 0;
	integer   msg_cnt = 0;
	integer   run_cnt = 0;
	reg       timed_out = 1'b0;
	reg       in_l0 = 1'b0;
	assign {rx_decode_err, rx_tlp, rx_ack, rx_eios, rx_eieos, rx_skp, rx_ts1} = sym_r;
	// count the wake stream; a skp set ends our fts receive state
	always @(posedge clk_sys)
	begin
		fts_cnt <= fts_cnt + tx_fts;
		skp_cnt <= skp_cnt + tx_skp;
		msg_cnt <= msg_cnt + tx_err_msg_r;
		if (tx_skp)
			in_l0 <= 1'b1;
		// receive timeout runs over fts seen before the first skp
		run_cnt <= (tx_fts && !in_l0) ? run_cnt + 1 : 0;
		if (run_cnt == NFTS_TIMEOUT)
			timed_out <= 1'b1;
		// replayed frames are counted here as duplicates
		dup_cnt <= dup_cnt + tx_replay_r;
	end
	// symbol a, then b straight after, then a quiet cycle
	task pair(input [6:0] a, input [6:0] b);
		@(negedge clk_sys) sym_r = a;
		@(negedge clk_sys) sym_r = b;
		@(negedge clk_sys) sym_r = 7'h00;
	endtask
endmodule // pltb_partner

// ### verif/pltb_link_train_tb.sv
`timescale 1ns/1ns
`include "pltb_regs.vh"
// ==========================================================
// self-checking bench for the link training block
module pltb_link_train_tb;
	localparam SYM = 2;
	localparam GEN = 2;
	localparam [6:0] TS1 = 7'h01, SKP = 7'h02, EIEOS = 7'h04, EIOS = 7'h08;
	localparam [6:0] ACK = 7'h10, TLP = 7'h20, DERR = 7'h40;
	reg         clk_sys, reset, pcie_refclk_enable, tlp_pending, cfg_accept_enter, hit;
	reg  [15:0] link_control;
	wire        rx_ts1, rx_skp, rx_eieos, rx_eios, rx_ack, rx_tlp, rx_decode_err;
	wire        tx_fts, tx_skp, tx_ts1_r, tx_ts1_lane_valid_r, tx_err_msg_r;
	wire        tx_ack_r, tx_replay_r, retrain_req_r;
	wire [7:0]  ltssm_state_r;
	integer     fails = 0, comparisons = 0, base_a, base_b;
	// lane match tied low: single lane builds must not look at it
	pltb_link_train #(.symbols_per_lane_param(SYM), .speed_generation_param(GEN)) i_dut (
		.clk_sys, .reset, .link_control, .pcie_refclk_enable, .tlp_pending,
		.cfg_accept_enter, .rx_ts1, .rx_skp, .rx_eieos, .rx_eios, .rx_ack, .rx_tlp,
		.rx_decode_err, .rx_link_lane_match(1'b0), .tx_fts, .tx_skp, .tx_ts1_r,
		.tx_ts1_lane_valid_r, .tx_err_msg_r, .tx_ack_r, .tx_replay_r, .retrain_req_r,
		.ltssm_state_r);
	pltb_partner i_partner (.clk_sys, .tx_fts, .tx_skp, .tx_replay_r, .tx_err_msg_r, .rx_ts1, .rx_skp,
		.rx_eieos, .rx_eios, .rx_ack, .rx_tlp, .rx_decode_err);
	// 20 MHz core clock
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task check(input [15:0] seen, input [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task final_report;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait for a state; running out ends the run
	task wait_st(input [7:0] s, input integer lim);
		for (int i = 0; i < lim && ltssm_state_r !== s; i++)
			@(negedge clk_sys);
		check(ltssm_state_r, s, "state");
		if (ltssm_state_r !== s)
			final_report;
	endtask
	task t_reset;
		reset = 1'b1;
		repeat (8) @(negedge clk_sys);
		check(ltssm_state_r, `PLTB_ST_DETECT, "reset state");
		reset = 1'b0;
		wait_st(`PLTB_ST_L0, 3);
	endtask
	// skp or eieos after a ts1 loses it; two clean ts1 enter recovery
	task t_ts1;
		i_partner.pair(TS1, SKP);
		i_partner.pair(TS1, EIEOS);
		check(ltssm_state_r, `PLTB_ST_L0, "ts1 lost");
		repeat (2) i_partner.pair(TS1, 7'h00);
		wait_st(`PLTB_ST_RCV_LOCK, 2);
		check(tx_ts1_r, 1'b1, "ts1 sent");
		repeat (3) i_partner.pair(TS1, 7'h00);
		wait_st(`PLTB_ST_L0, 2);
	endtask
	// accept lasts one cycle, so the lane flag may show in either
	task t_cfg;
		cfg_accept_enter = 1'b1;
		@(negedge clk_sys) cfg_accept_enter = 1'b0;
		check(ltssm_state_r, `PLTB_ST_CFG_ACCEPT, "accept");
		check(tx_ts1_r, 1'b1, "ts1 in accept");
		hit = tx_ts1_lane_valid_r;
		@(negedge clk_sys) hit = hit | tx_ts1_lane_valid_r;
		check(hit, 1'b1, "lane valid");
	endtask
	// the ack stands for one cycle, just as the pair returns
	task t_tlp;
		i_partner.pair(TLP, 7'h00);
		check(tx_ack_r, 1'b1, "ack");
		i_partner.pair(TLP, EIOS);
		check(tx_ack_r, 1'b0, "lost ack");
	endtask
	// unanswered message: three replays, then the timer forces retraining;
	// an ack chased by eios is dropped and must not stop the replays
	task t_err;
		base_a = i_partner.msg_cnt;
		base_b = i_partner.dup_cnt;
		i_partner.pair(DERR, 7'h00);
		i_partner.pair(ACK, EIOS);
		for (int i = 0; i < 5000 && ltssm_state_r !== `PLTB_ST_RCV_LOCK; i++)
			@(negedge clk_sys);
		check(i_partner.msg_cnt - base_a, 4, "messages");
		check(i_partner.dup_cnt - base_b, 3, "replays");
		wait_st(`PLTB_ST_RCV_LOCK, 1);
		repeat (3) i_partner.pair(TS1, 7'h00);
		wait_st(`PLTB_ST_L0, 2);
	endtask
	// idle into l0s, wake on a tlp and count the training sets
	task t_fts(input bit ext);
		link_control = 16'h0001 | (16'(ext) << `PLTB_LC_EXT_SYNCH);
		wait_st(`PLTB_ST_L0S, 60);
		base_a = i_partner.fts_cnt;
		base_b = i_partner.skp_cnt;
		tlp_pending = 1'b1;
		wait_st(`PLTB_ST_L0S_EXIT, 3);
		wait_st(`PLTB_ST_L0, 4500);
		tlp_pending = 1'b0;
		link_control = 16'h0000;
		check(i_partner.fts_cnt - base_a, (ext && SYM >= 2 && GEN == 2) ? 4097 : 4096, "fts");
		check(ext ? i_partner.skp_cnt - base_b >= 12 : i_partner.skp_cnt == base_b, 1'b1, "skp");
		if (ext)
		begin
			check(i_partner.in_l0, 1'b1, "partner l0");
			check(i_partner.timed_out, 1'b0, "fts timeout");
		end
	endtask
	// reference clock gated around a warm reset
	task t_refclk;
		pcie_refclk_enable = 1'b0;
		wait_st(`PLTB_ST_DETECT, 2);
		reset = 1'b1;
		@(negedge clk_sys) pcie_refclk_enable = 1'b1;
		t_reset;
	endtask
	initial
	begin
		reset = 1'b1;
		link_control = 16'h0000;
		pcie_refclk_enable = 1'b1;
		tlp_pending = 1'b0;
		cfg_accept_enter = 1'b0;
		t_reset;
		t_ts1;
		t_cfg;
		t_tlp;
		t_err;
		t_fts(1'b1);
		t_fts(1'b0);
		t_refclk;
		final_report;
	end
endmodule // pltb_link_train_tb
